// ===== scc_far_model.sv
// far side: queue, input and forwarding control, port status
// assumes pclk from the bench; the bench calls its tasks
`timescale 1ns/1ps
module scc_far_model
    import scc_pkg::*;
(
    // clock
    input  wire logic            pclk,
    // status and counts
    output logic [NPORT-1:0]     port_half,
    output logic [NPORT-1:0]     port_partner_fc,
    output logic                 port_status_valid,
    output logic [CW-1:0]        free_cnt,
    output logic [NQ*CW-1:0]     qlen,
    // events
    output logic                 enq_done,
    output logic [3:0]           enq_src,
    output logic [NQ-1:0]        enq_dst,
    output logic                 enq_bcast,
    output logic [NPORT-1:0]     nonlocal,
    output logic                 lk_valid,
    output logic [3:0]           lk_src,
    output logic [NQ-1:0]        lk_mask
);
    initial begin
        {port_half, port_partner_fc, port_status_valid, qlen} = '0;
        {enq_done, enq_dst, enq_bcast, nonlocal, lk_valid, lk_mask} = '0;
        {enq_src, lk_src} = 8'hff;
        free_cnt = 10'h0c8;
    end

    task automatic status(input logic [NPORT-1:0] h,
                          input logic [NPORT-1:0] f);
        @(posedge pclk);
        port_half <= h;
        port_partner_fc <= f;
        port_status_valid <= 1'b1;
        @(posedge pclk);
        port_status_valid <= 1'b0;
    endtask

    // derived counts are registered, so let them settle
    task automatic counts(input logic [CW-1:0] f,
                          input logic [NQ*CW-1:0] q);
        @(posedge pclk);
        free_cnt <= f;
        qlen <= q;
        repeat (3) @(posedge pclk);
    endtask

    // released fields show their inverse, not a stale copy
    task automatic enqueue(input logic [3:0] s);
        @(posedge pclk);
        enq_done <= 1'b1;
        enq_src <= s;
        enq_dst <= 10'h001;
        @(posedge pclk);
        enq_done <= 1'b0;
        enq_src <= ~s;
        enq_dst <= 10'h3fe;
    endtask

    task automatic flag(input logic [NPORT-1:0] m);
        @(posedge pclk);
        nonlocal <= m;
        @(posedge pclk);
        nonlocal <= '0;
    endtask

    task automatic lookup(input logic [3:0] s, input logic [NQ-1:0] m);
        @(posedge pclk);
        lk_valid <= 1'b1;
        lk_src <= s;
        lk_mask <= m;
        @(posedge pclk);
        lk_valid <= 1'b0;
        lk_src <= ~s;
        lk_mask <= ~m;
    endtask
endmodule

// ===== scc_pkg.sv
// switch congestion control: shared constants, offsets, reset values
// assumes a single pclk domain; all users import scc_pkg::*
// Function
// - pause only with fc enabled, partner capable
// - fc partner full duplex: drop off
// - backpressure on half duplex, drop off
// - drop on otherwise when drop enabled
// - violating enqueue moves fc or backpressure source to xoff
// - windows kept per port from events
// - xon event in xon is ignored
// - every xoff trigger of a pause (fc) port sends max pause
// - violating enqueue signals fc source pause frame
// - non-local packet collided when half, xoff
// - lookup clears mask if drop and congested
// - congested: drop enable, any xoff, zero reservation
// - starvation threshold nine, decide on virtual free
// - virtual free is free minus reserve constant
// - reservation is max minus queue, floor zero
// - total reservation sums queues zero to nine
// - xoff entry conditions on free and reservation
// - all ports leave xoff above xon threshold
// - xon threshold half buffers plus xoff minus twenty; here xon_thr is a fixed register, reset from the memory size table
// - per memory size xon and rmax table
// - xoff level never below total reservation
package scc_pkg;

    // ********************************
    // sizes
    // ********************************
    localparam int NPORT = 8;
    localparam int NQ    = 10;
    localparam int CW    = 10;

    // ********************************
    // apb register map (byte offsets)
    // ********************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_DUPLEX  = 8'h04;
    localparam logic [7:0] OFS_PARTFC  = 8'h08;
    localparam logic [7:0] OFS_XONTHR  = 8'h0c;
    localparam logic [7:0] OFS_RMAX    = 8'h10;
    localparam logic [7:0] OFS_RESVC   = 8'h14;
    localparam logic [7:0] OFS_MINXOFF = 8'h18;
    localparam logic [7:0] OFS_STATUS  = 8'h1c;
    localparam logic [7:0] OFS_VFREE   = 8'h20;
    localparam logic [7:0] OFS_PSI     = 8'h24;

    // ********************************
    // field positions
    // ********************************
    localparam int CTRL_FC_BIT   = 0;
    localparam int CTRL_DROP_BIT = 1;
    localparam int ST_XOFF_LSB   = 0;
    localparam int ST_DROP_LSB   = 8;
    localparam int ST_CONG_LSB   = 16;

    // ********************************
    // constants and reset values
    // ********************************
    localparam logic [15:0]   PAUSE_MAX  = 16'hffff;
    localparam logic [CW-1:0] STARVE_THR = 10'h009;
    localparam logic [CW-1:0] RESV_C_DEF = 10'h00a;
    localparam logic [CW-1:0] MIN_XOFF_DEF = 10'h01c;
    localparam logic          FC_EN_RST  = 1'b0;
    localparam logic          DROP_EN_RST = 1'b0;

    // memory size selection 0:128KB 1:256KB 2:512KB 3:1MB
    localparam logic [CW-1:0] XON_128K = 10'h02b;
    localparam logic [CW-1:0] XON_256K = 10'h062;
    localparam logic [CW-1:0] XON_512K = 10'h0c6;
    localparam logic [CW-1:0] XON_1M   = 10'h17d;
    localparam logic [4:0]    RMAX_128K = 5'h01;
    localparam logic [4:0]    RMAX_256K = 5'h04;
    localparam logic [4:0]    RMAX_512K = 5'h06;
    localparam logic [4:0]    RMAX_1M   = 5'h08;

endpackage

// ===== scc_policy.sv
// per-port choice of pause, backpressure or drop control
// assumes duplex and partner capability are settled levels
`timescale 1ns/1ps
module scc_policy
    import scc_pkg::*;
(
    // feature enables
    input  wire logic              fc_en,
    input  wire logic              drop_en,
    // port status
    input  wire logic [NPORT-1:0]  half,
    input  wire logic [NPORT-1:0]  partner_fc,
    // per-port policy
    output logic      [NPORT-1:0]  fc_act,
    output logic      [NPORT-1:0]  bp_act,
    output logic      [NPORT-1:0]  drop_act
);
    for (genvar p = 0; p < NPORT; p++) begin : g_pol
        assign fc_act[p] = fc_en & ~half[p] & partner_fc[p];
        assign bp_act[p] = fc_en & half[p];
        assign drop_act[p] = drop_en &
                             (~fc_en | (~half[p] & ~partner_fc[p]));
    end
endmodule

// ===== scc_thresh.sv
// virtual free count, per-queue reservations and their total
// assumes free count and queue lengths come from same-clock logic
`timescale 1ns/1ps
module scc_thresh
    import scc_pkg::*;
(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // counts in
    input  wire logic [CW-1:0]         free_cnt,
    input  wire logic [NQ*CW-1:0]      qlen,
    input  wire logic [4:0]            rmax,
    input  wire logic [CW-1:0]         resv_c,
    // derived out, registered
    output logic      [CW-1:0]         omega,
    output logic      [CW-1:0]         psi,
    output logic      [NQ-1:0]         rk_zero
);
    typedef struct packed {
        logic [CW-1:0] omega;
        logic [CW-1:0] psi;
        logic [NQ-1:0] rkz;
    } scc_thr_t;

    scc_thr_t       s_q;
    scc_thr_t       s_d;
    logic [CW-1:0]  rk [NQ];
    logic [CW-1:0]  rmax_w;

    assign rmax_w = {5'h00, rmax};

    for (genvar k = 0; k < NQ; k++) begin : g_rk
        assign rk[k] = (qlen[k*CW +: CW] >= rmax_w) ? '0 :
                       rmax_w - qlen[k*CW +: CW];
    end

    always_comb begin
        s_d = s_q;
        s_d.omega = (free_cnt <= resv_c) ? '0 : free_cnt - resv_c;
        s_d.psi = '0;
        for (int k = 0; k < NQ; k++) begin
            s_d.psi = s_d.psi + rk[k];
            s_d.rkz[k] = (rk[k] == '0);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign omega   = s_q.omega;
    assign psi     = s_q.psi;
    assign rk_zero = s_q.rkz;
endmodule

// ===== scc_top.sv
// congestion control for an eight-port shared-memory switch
// assumes queue, input and forwarding control share pclk
`timescale 1ns/1ps
module scc_top
    import scc_pkg::*;
#(
    parameter logic [1:0] MEM_SEL = 2'h1
)(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // port status
    input  wire logic [NPORT-1:0]      port_half,
    input  wire logic [NPORT-1:0]      port_partner_fc,
    input  wire logic                  port_status_valid,
    // buffer and queue counts
    input  wire logic [CW-1:0]         free_cnt,
    input  wire logic [NQ*CW-1:0]      qlen,
    // enqueue events from queue control
    input  wire logic                  enq_done,
    input  wire logic [3:0]            enq_src,
    input  wire logic [NQ-1:0]         enq_dst,
    input  wire logic                  enq_bcast,
    // non-local flags from input control
    input  wire logic [NPORT-1:0]      nonlocal,
    // lookup from forwarding control
    input  wire logic                  lk_valid,
    input  wire logic [3:0]            lk_src,
    input  wire logic [NQ-1:0]         lk_mask,
    output logic                       lk_out_valid,
    output logic      [NQ-1:0]         lk_out_mask,
    // transmit mac unit requests
    output logic      [NPORT-1:0]      pause_req,
    output logic      [15:0]           pause_time,
    output logic      [NPORT-1:0]      force_col,
    // windows
    output logic      [NPORT-1:0]      pause_state_window,
    output logic      [NPORT-1:0]      drop_window,
    output logic      [NQ-1:0]         congested
);
    // ********************************
    // reset defaults by memory size
    // ********************************
    // threshold and reservation table
    function automatic logic [CW-1:0] xon_def(input logic [1:0] sel);
        unique case (sel)
            2'h0: xon_def = XON_128K;
            2'h1: xon_def = XON_256K;
            2'h2: xon_def = XON_512K;
            2'h3: xon_def = XON_1M;
        endcase
    endfunction

    function automatic logic [4:0] rmax_def(input logic [1:0] sel);
        unique case (sel)
            2'h0: rmax_def = RMAX_128K;
            2'h1: rmax_def = RMAX_256K;
            2'h2: rmax_def = RMAX_512K;
            2'h3: rmax_def = RMAX_1M;
        endcase
    endfunction

    localparam logic [CW-1:0] XON_RST  = xon_def(MEM_SEL);
    localparam logic [4:0]    RMAX_RST = rmax_def(MEM_SEL);

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic             fc_en;
        logic             drop_en;
        logic [NPORT-1:0] half;
        logic [NPORT-1:0] pfc;
        logic [CW-1:0]    xon_thr;
        logic [4:0]       rmax;
        logic [CW-1:0]    resv_c;
        logic [CW-1:0]    min_xoff;
        logic [NPORT-1:0] xoff;
        logic [NPORT-1:0] dropw;
        logic [NPORT-1:0] pause;
        logic [NPORT-1:0] col;
        logic             lk_v;
        logic [NQ-1:0]    lk_m;
        logic [31:0]      rdata;
    } scc_state_t;

    scc_state_t        s_q;
    scc_state_t        s_d;

    logic [CW-1:0]     omega;
    logic [CW-1:0]     psi;
    logic [NQ-1:0]     rk_zero;
    logic [NPORT-1:0]  fc_act;
    logic [NPORT-1:0]  bp_act;
    logic [NPORT-1:0]  drop_act;
    logic [CW-1:0]     xoff_lvl;
    logic [NPORT-1:0]  xoff_cond;
    logic [NQ-1:0]     cong_w;
    logic              any_xoff;
    logic              setup;
    logic              wr_acc;
    logic              addr_ok;

    // ********************************
    // submodules
    // ********************************
    scc_thresh u_thresh (
        .pclk     (pclk),
        .presetn  (presetn),
        .free_cnt (free_cnt),
        .qlen     (qlen),
        .rmax     (s_q.rmax),
        .resv_c   (s_q.resv_c),
        .omega    (omega),
        .psi      (psi),
        .rk_zero  (rk_zero)
    );

    scc_policy u_policy (
        .fc_en      (s_q.fc_en),
        .drop_en    (s_q.drop_en),
        .half       (s_q.half),
        .partner_fc (s_q.pfc),
        .fc_act     (fc_act),
        .bp_act     (bp_act),
        .drop_act   (drop_act)
    );

    // ********************************
    // congestion terms
    // ********************************
    assign any_xoff = |s_q.xoff;

    // xoff level never under total reservation
    assign xoff_lvl = (psi > s_q.min_xoff) ? psi : s_q.min_xoff;

    for (genvar k = 0; k < NPORT; k++) begin : g_cond
        assign xoff_cond[k] = (omega == '0) |
                              ((omega <= xoff_lvl) & rk_zero[k]) |
                              (any_xoff & rk_zero[k]);
    end

    for (genvar k = 0; k < NQ; k++) begin : g_cong
        assign cong_w[k] = s_q.drop_en & any_xoff & rk_zero[k];
    end

    // ********************************
    // apb decode
    // ********************************
    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;

    always_comb begin
        unique case (paddr)
            OFS_CTRL, OFS_DUPLEX, OFS_PARTFC, OFS_XONTHR, OFS_RMAX,
            OFS_RESVC, OFS_MINXOFF, OFS_STATUS, OFS_VFREE,
            OFS_PSI: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // ********************************
    // next state
    // ********************************
    always_comb begin
        s_d       = s_q;
        s_d.pause = '0;
        s_d.col   = '0;
        s_d.lk_v  = 1'b0;

        if (port_status_valid) begin
            s_d.half = port_half;
            s_d.pfc  = port_partner_fc;
        end

        // read data captured in setup so access needs no wait
        if (setup) begin
            s_d.rdata = '0;
            unique case (paddr)
                OFS_CTRL: begin
                    s_d.rdata[CTRL_FC_BIT]   = s_q.fc_en;
                    s_d.rdata[CTRL_DROP_BIT] = s_q.drop_en;
                end
                OFS_DUPLEX:  s_d.rdata[NPORT-1:0] = s_q.half;
                OFS_PARTFC:  s_d.rdata[NPORT-1:0] = s_q.pfc;
                OFS_XONTHR:  s_d.rdata[CW-1:0]    = s_q.xon_thr;
                OFS_RMAX:    s_d.rdata[4:0]       = s_q.rmax;
                OFS_RESVC:   s_d.rdata[CW-1:0]    = s_q.resv_c;
                OFS_MINXOFF: s_d.rdata[CW-1:0]    = s_q.min_xoff;
                OFS_STATUS: begin
                    s_d.rdata[ST_XOFF_LSB +: NPORT] = s_q.xoff;
                    s_d.rdata[ST_DROP_LSB +: NPORT] = s_q.dropw;
                    s_d.rdata[ST_CONG_LSB +: NQ]    = cong_w;
                end
                OFS_VFREE:   s_d.rdata[CW-1:0]    = omega;
                OFS_PSI:     s_d.rdata[CW-1:0]    = psi;
                default:     s_d.rdata            = '0;
            endcase
        end

        if (wr_acc) begin
            unique case (paddr)
                OFS_CTRL: begin
                    s_d.fc_en   = pwdata[CTRL_FC_BIT];
                    s_d.drop_en = pwdata[CTRL_DROP_BIT];
                end
                // software override; next status update replaces it
                OFS_DUPLEX:  s_d.half     = pwdata[NPORT-1:0];
                OFS_PARTFC:  s_d.pfc      = pwdata[NPORT-1:0];
                // software programs the fixed xon level
                OFS_XONTHR:  s_d.xon_thr  = pwdata[CW-1:0];
                OFS_RMAX:    s_d.rmax     = pwdata[4:0];
                OFS_RESVC: begin
                    s_d.resv_c = (pwdata[CW-1:0] > STARVE_THR) ?
                                 pwdata[CW-1:0] : RESV_C_DEF;
                end
                OFS_MINXOFF: s_d.min_xoff = pwdata[CW-1:0];
                default: ;
            endcase
        end

        s_d.dropw = drop_act;

        // leave xoff above threshold, all ports at once
        // clearing an xon port changes nothing
        if (omega > s_q.xon_thr) begin
            s_d.xoff = '0;
        end

        // violating enqueue, after the enqueue ends
        if (enq_done && (enq_src < 4'(NPORT))) begin
            if (xoff_cond[enq_src[2:0]] ||
                (enq_bcast && |(enq_dst[NPORT-1:0] & s_q.xoff))) begin
                // set wins over a same-cycle xon
                if (fc_act[enq_src[2:0]] || bp_act[enq_src[2:0]]) begin
                    s_d.xoff[enq_src[2:0]] = 1'b1;
                end
                // repeated on every trigger, even in xoff
                if (fc_act[enq_src[2:0]]) begin
                    s_d.pause[enq_src[2:0]] = 1'b1;
                end
            end
        end

        // collide non-local packets on half-duplex xoff
        s_d.col = nonlocal & bp_act & s_q.xoff;

        // unmask so input control discards it
        if (lk_valid) begin
            s_d.lk_v = 1'b1;
            s_d.lk_m = lk_mask;
            if ((lk_src < 4'(NPORT)) && s_q.dropw[lk_src[2:0]] &&
                |(lk_mask & cong_w)) begin
                s_d.lk_m = '0;
            end
        end
    end

    // ********************************
    // registers
    // ********************************
    // xon, no drop window, no pause after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q          <= '0;
            s_q.fc_en    <= FC_EN_RST;
            s_q.drop_en  <= DROP_EN_RST;
            s_q.xon_thr  <= XON_RST;
            s_q.rmax     <= RMAX_RST;
            s_q.resv_c   <= RESV_C_DEF;
            s_q.min_xoff <= MIN_XOFF_DEF;
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign prdata             = s_q.rdata;
    assign pready             = 1'b1;
    assign pslverr            = psel & penable & ~addr_ok;
    assign pause_req          = s_q.pause;
    assign pause_time         = PAUSE_MAX;
    assign force_col          = s_q.col;
    assign pause_state_window = s_q.xoff;
    assign drop_window        = s_q.dropw;
    assign congested          = cong_w;
    assign lk_out_valid       = s_q.lk_v;
    assign lk_out_mask        = s_q.lk_m;
endmodule

// ===== scc_top_assertions.sv
// checker: congestion outputs of scc_top against their causes
// assumes it is bound into scc_top, one pclk domain
`timescale 1ns/1ps
module scc_top_assertions
    import scc_pkg::*;
#(
    parameter logic [1:0] MEM_SEL = 2'h1
)(
    // clock and reset
    input wire logic             pclk,
    input wire logic             presetn,
    // events in
    input wire logic             enq_done,
    input wire logic [NPORT-1:0] nonlocal,
    input wire logic             lk_valid,
    input wire logic [3:0]       lk_src,
    input wire logic [NQ-1:0]    lk_mask,
    // results out
    input wire logic             lk_out_valid,
    input wire logic [NQ-1:0]    lk_out_mask,
    input wire logic [NPORT-1:0] pause_req,
    input wire logic [15:0]      pause_time,
    input wire logic [NPORT-1:0] force_col,
    input wire logic [NPORT-1:0] pause_state_window,
    input wire logic [NPORT-1:0] drop_window,
    input wire logic [NQ-1:0]    congested
);
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // *****
    // lookup steps
    // *****
    sequence lk_drop_s;
        lk_valid && lk_src < 4'h8 && drop_window[lk_src[2:0]]
            && (lk_mask & congested) != '0;
    endsequence
    sequence lk_keep_s;
        lk_valid && !(lk_src < 4'h8 && drop_window[lk_src[2:0]]);
    endsequence

    pause_max_a: assert property (pause_time == 16'hffff)
        else $error("pause time not at maximum");
    reset_quiet_a: assert property ($rose(presetn) |->
        pause_req == '0 && pause_state_window == '0 && force_col == '0)
        else $error("outputs active right after reset");
    pause_cause_a: assert property (pause_req != '0 |->
        $past(enq_done))
        else $error("pause request without an enqueue");
    pause_win_a: assert property (pause_req != '0 |->
        (pause_req & ~pause_state_window) == '0)
        else $error("pause request outside the pause_state_window");
    win_rise_a: assert property ((pause_state_window
        & ~$past(pause_state_window)) != '0 |-> $past(enq_done))
        else $error("pause_state_window opened without an enqueue");
    col_cause_a: assert property (force_col != '0 |->
        (force_col & ~$past(nonlocal & pause_state_window)) == '0)
        else $error("collision forced without cause");
    lk_pulse_a: assert property (lk_out_valid == $past(lk_valid))
        else $error("lookup answer not one cycle later");
    lk_keep_a: assert property (lk_keep_s |=>
        lk_out_mask == $past(lk_mask))
        else $error("lookup mask altered");
    lk_drop_a: assert property (lk_drop_s |=> lk_out_mask == '0)
        else $error("lookup mask not cleared");
    cong_xoff_a: assert property (congested != '0 |->
        pause_state_window != '0)
        else $error("congested while no port is in xoff");
endmodule

bind scc_top scc_top_assertions #(.MEM_SEL(MEM_SEL)) u_chk (
    .pclk, .presetn, .enq_done, .nonlocal, .lk_valid, .lk_src,
    .lk_mask, .lk_out_valid, .lk_out_mask, .pause_req, .pause_time,
    .force_col, .pause_state_window, .drop_window, .congested
);

// ===== switch_congestion_control_tb.sv
// testbench for scc_top: apb reads, far-side events, windows
// assumes scc_far_model drives every far-side input
`timescale 1ns/1ps
module switch_congestion_control_tb;
    import scc_pkg::*;
    logic             pclk, presetn, psel, penable, pwrite;
    logic             pready, pslverr, port_status_valid, e;
    logic             enq_done, enq_bcast, lk_valid, lk_out_valid;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, r;
    logic [3:0]       enq_src, lk_src;
    logic [15:0]      pause_time;
    logic [CW-1:0]    free_cnt, x10;
    logic [NQ*CW-1:0] qlen, q;
    logic [NQ-1:0]    enq_dst, lk_mask, lk_out_mask, congested;
    logic [NPORT-1:0] port_half, port_partner_fc, nonlocal, pause_req;
    logic [NPORT-1:0] force_col, pause_state_window, drop_window, x8;
    logic [CW-1:0]    fv [4];
    int               n_mismatch, check_count, cycles;

    scc_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_half(port_half),
        .port_partner_fc(port_partner_fc),
        .port_status_valid(port_status_valid),
        .free_cnt(free_cnt), .qlen(qlen), .enq_done(enq_done),
        .enq_src(enq_src), .enq_dst(enq_dst), .enq_bcast(enq_bcast),
        .nonlocal(nonlocal), .lk_valid(lk_valid), .lk_src(lk_src),
        .lk_mask(lk_mask), .lk_out_valid(lk_out_valid),
        .lk_out_mask(lk_out_mask), .pause_req(pause_req),
        .pause_time(pause_time), .force_col(force_col),
        .pause_state_window(pause_state_window),
        .drop_window(drop_window), .congested(congested)
    );
    scc_far_model far (
        .pclk(pclk), .port_half(port_half),
        .port_partner_fc(port_partner_fc),
        .port_status_valid(port_status_valid),
        .free_cnt(free_cnt), .qlen(qlen), .enq_done(enq_done),
        .enq_src(enq_src), .enq_dst(enq_dst), .enq_bcast(enq_bcast),
        .nonlocal(nonlocal), .lk_valid(lk_valid), .lk_src(lk_src),
        .lk_mask(lk_mask)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // *****
    // tasks
    // *****
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk_out(string n, logic [31:0] x, logic [31:0] g);
        check_count++;
        if (g !== x) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic chk_reg(string n, logic [7:0] a, logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk_out(n, x, r);
    endtask

    task automatic enq_chk(logic [3:0] s, logic [7:0] p, logic [7:0] w);
        far.enqueue(s);
        #1;
        chk_out("pause req", 32'(p), 32'(pause_req));
        chk_out("pause_state_window", 32'(w), 32'(pause_state_window));
    endtask

    task automatic lk_chk(logic [3:0] s, logic [9:0] m, logic [9:0] x);
        far.lookup(s, m);
        #1;
        chk_out("lookup valid", 32'h1, 32'(lk_out_valid));
        chk_out("lookup mask", 32'(x), 32'(lk_out_mask));
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, far above the run length
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // *****
    // tests
    // *****
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {n_mismatch, check_count} = '0;
        fv = '{10'h005, 10'h00a, 10'h00b, 10'h0c8};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk_reg("ctrl", OFS_CTRL, 32'h0);
        chk_reg("xon thr", OFS_XONTHR, 32'h62);
        chk_reg("rmax", OFS_RMAX, 32'h4);
        chk_reg("min xoff", OFS_MINXOFF, 32'h1c);
        chk_reg("status", OFS_STATUS, 32'h0);
        apb(1'b1, OFS_RESVC, 32'h9);
        chk_reg("resv c", OFS_RESVC, 32'ha);
        chk_reg("bad addr", 8'h28, 32'h0);
        chk_out("slverr", 32'h1, 32'(e));
        $display("test reset done");
        far.status(8'h0f, 8'h33);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_CTRL, 32'(i));
            x8 = {8{i[1]}} & ~({8{i[0]}} & (8'h0f | 8'h33));
            chk_reg("drop win", OFS_STATUS, {16'h0, x8, 8'h0});
            chk_out("drop pin", 32'(x8), 32'(drop_window));
        end
        $display("test policy done");
        q = {{7{10'h004}}, 10'h003, 10'h001, 10'h000};
        for (int i = 0; i < 4; i++) begin
            far.counts(fv[i], q);
            chk_reg("psi", OFS_PSI, 32'h8);
            x10 = (fv[i] <= 10'h00a) ? 10'h000 : fv[i] - 10'h00a;
            chk_reg("vfree", OFS_VFREE, 32'(x10));
        end
        $display("test counts done");
        q = {NQ{10'h004}};
        far.counts(10'h027, q);
        enq_chk(4'h4, 8'h00, 8'h00);
        far.counts(10'h026, q);
        enq_chk(4'h4, 8'h10, 8'h10);
        enq_chk(4'h4, 8'h10, 8'h10);
        chk_out("pause time", 32'h0000ffff, 32'(pause_time));
        enq_chk(4'h0, 8'h00, 8'h11);
        enq_chk(4'h6, 8'h00, 8'h11);
        far.flag(8'h13);
        #1;
        chk_out("force col", 32'h1, 32'(force_col));
        $display("test xoff done");
        q[29:20] = 10'h000;
        far.counts(10'h026, q);
        chk_reg("congestion", OFS_STATUS, 32'h03fbc011);
        lk_chk(4'h6, 10'h004, 10'h004);
        lk_chk(4'h6, 10'h00c, 10'h000);
        lk_chk(4'h4, 10'h00c, 10'h00c);
        apb(1'b1, OFS_CTRL, 32'h1);
        #1;
        chk_out("no drop", 32'h0, 32'(congested));
        $display("test drop done");
        far.counts(10'h06c, q);
        chk_out("at xon thr", 32'h11, 32'(pause_state_window));
        far.counts(10'h06d, q);
        #1;
        chk_out("above xon", 32'h0, 32'(pause_state_window));
        q[59:50] = 10'h000;
        far.counts(10'h00a, q);
        enq_chk(4'h5, 8'h20, 8'h20);
        $display("test xon done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk_out("reset win", 32'h0, 32'(pause_state_window));
        chk_reg("reset status", OFS_STATUS, 32'h0);
        $display("test reset 2 done");
        report_and_stop();
    end
endmodule
